// >>> hdl/pda_pkg.sv
/*
  Shared constants, carrier structs and state enums for the receive lane
  alignment block. Assumes a single 20 MHz clock for every user.
*/
package pda_pkg;

  // Clock
  localparam int CLK_MHZ           = 20;

  // Block and lane geometry
  localparam int BLK_W             = 66;
  localparam int LANE_NUM_W        = 5;
  localparam int LANES_40G         = 4;
  localparam int LANES_100G        = 20;

  // Marker spacing and loss of lock
  localparam int AM_PERIOD_BLKS    = 16384;
  localparam int AM_ERR_LIMIT      = 4;

  // Marker field positions inside a 66-bit block
  localparam int AM_LO_POS         = 2;
  localparam int AM_PARITY_POS     = 26;
  localparam int AM_HI_POS         = 34;

  // Skew budget: time, bits at lane rate, blocks to buffer
  localparam int SKEW_MAX_NS       = 180;
  localparam int SKEW_VAR_NS       = 4;
  localparam int SKEW_RSFEC_NS     = 49;
  localparam int SKEW_MAX_BITS     = 1856;
  localparam int SKEW_VAR_BITS     = 41;
  localparam int SKEW_BLKS         =
    (SKEW_MAX_BITS + SKEW_VAR_BITS + BLK_W - 1) / BLK_W;
  localparam int DESKEW_DEPTH      = 2 ** $clog2(SKEW_BLKS + 2);

  // Error-rate monitor
  localparam int BER_CNT_W         = 7;
  localparam logic [6:0] HIGH_ERROR_RATE_FLAG_THRESH = 7'h61;
  localparam int BER_WINDOW_US     = 125;
  localparam int BER_WINDOW_CYC    = BER_WINDOW_US * CLK_MHZ;

  // Error counters
  localparam int ERR_CNT_W         = 16;

  // Sync headers (bit 0 is first received) and control codes
  localparam logic [1:0]  SH_DATA       = 2'h2;
  localparam logic [1:0]  SH_CTRL       = 2'h1;
  localparam logic [7:0]  CTRL_IDLE_TYPE = 8'h1E;
  localparam logic [7:0]  MII_IDLE      = 8'h07;
  localparam logic [7:0]  MII_ERROR     = 8'hFE;
  localparam logic [7:0]  MII_ALL_CTRL  = 8'hFF;
  localparam logic [7:0]  LF_RXC        = 8'h11;
  localparam logic [63:0] LF_RXD        = 64'h0100_009C_0100_009C;

  // Self-synchronising descrambler x^58 + x^39 + 1
  localparam int SCR_W             = 58;
  localparam int SCR_TAP_A         = 38;
  localparam int SCR_TAP_B         = 57;

  typedef struct packed {
    logic             valid;
    logic [BLK_W-1:0] blk;
  } pda_lane_blk_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rxc;
    logic [63:0] rxd;
  } pda_mii_s;

  typedef enum logic [1:0] {AML_FIND, AML_CONFIRM, AML_LOCKED} pda_aml_e;
  typedef enum logic [1:0] {DSK_IDLE, DSK_WAIT, DSK_RUN} pda_dsk_e;

endpackage : pda_pkg

// >>> hdl/pda_skew_mem.sv
/*
  Simple dual-port block store for one lane of the deskew buffer.
  Assumes writer and reader share clock_i; read data is registered.
*/
`timescale 1ns/1ps
module pda_skew_mem #(
  parameter int W     = 67,
  parameter int DEPTH = 32
) (
  input  wire logic                     clock_i,
  input  wire logic                     rstn_i,
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input  wire logic [W-1:0]             wr_data_i,
  input  wire logic                     rd_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic      [W-1:0]             rd_data_o
);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] rd_data_r;

  // Array carries no reset; only the read register does
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_r <= '0;
    end else if (rd_en_i) begin
      rd_data_r <= mem_r[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_r;

endmodule : pda_skew_mem

// >>> hdl/pda_lane_align.sv
/*
  Receive lane alignment: per-lane marker lock, deskew, reorder, marker
  removal with parity check, idle fill, simple decode to 72-bit transfers,
  error-rate monitor and scrambled idle checker.
  Assumes lane blocks arrive already block-delineated, on clock_i.
*/
`timescale 1ns/1ps
module pda_lane_align
  import pda_pkg::*;
#(
  parameter int LANES      = LANES_40G,
  parameter int AM_PERIOD  = AM_PERIOD_BLKS,
  parameter int DEPTH      = DESKEW_DEPTH,
  parameter int BER_WINDOW = BER_WINDOW_CYC
) (
  input  wire logic                                clock_i,
  input  wire logic                                rstn_i,
  input  wire pda_lane_blk_s [LANES-1:0]           lane_blk_i,
  input  wire logic [LANES-1:0]                    block_lock_i,
  input  wire logic                                test_mode_i,
  output pda_mii_s                                 mii_o,
  output logic [LANES-1:0]                         lane_marker_locked_o,
  output logic                                     all_lanes_marker_locked_o,
  output logic [LANES-1:0][LANE_NUM_W-1:0]         lane_mapping_o,
  output logic                                     deskew_enable_o,
  output logic                                     align_status_o,
  output logic                                     high_error_rate_flag_o,
  output logic                                     link_good_flag_o,
  output logic [LANES-1:0][ERR_CNT_W-1:0]          parity_err_cnt_o,
  output logic [ERR_CNT_W-1:0]                     test_err_cnt_o
);

  localparam int AW  = $clog2(DEPTH);
  localparam int CW  = $clog2(AM_PERIOD);
  localparam int LW  = LANE_NUM_W;
  localparam int EW  = BLK_W + 1;
  localparam int BWW = $clog2(BER_WINDOW + 1);
  localparam int EC  = $clog2(AM_ERR_LIMIT);
  localparam int SW  = $clog2(LANES + 1);
  localparam int FL  = (AM_PERIOD / 2 < DEPTH) ? AM_PERIOD / 2 : DEPTH;

  typedef struct packed {
    pda_aml_e [LANES-1:0]           aml;
    logic [LANES-1:0][CW-1:0]       cnt;
    logic [LANES-1:0][LW-1:0]       init_num;
    logic [LANES-1:0][EC-1:0]       err_cnt;
    logic [LANES-1:0][7:0]          bip;
    logic [LANES-1:0][ERR_CNT_W-1:0] par_cnt;
    logic [LANES-1:0]               locked;
    logic [LANES-1:0]               started;
    logic [LANES-1:0][AW:0]         wr_ptr;
    logic                           all_locked;
    pda_dsk_e                       dsk;
    logic                           dsk_en;
    logic [AW:0]                    rd_ptr;
    logic                           rd_pend;
    logic                           row_full;
    logic [LW-1:0]                  idx;
    logic [LANES-1:0][EW-1:0]       row;
    logic [SCR_W-1:0]               scr;
    logic [BER_CNT_W-1:0]           ber_cnt;
    logic [BWW-1:0]                 ber_win;
    logic                           high_error_rate_flag;
    logic                           align;
    logic                           link_good;
    logic [ERR_CNT_W-1:0]           test_cnt;
    pda_mii_s                       mii;
  } pda_state_s;

  pda_state_s               s_r;
  pda_state_s               s_nxt;
  logic [LANES-1:0]         wr_en;
  logic [LANES-1:0][EW-1:0] wr_data;
  logic                     rd_en;
  logic [LANES-1:0][EW-1:0] rd_data;
  logic [LW:0]              hit;
  logic                     at_pos;
  logic                     mark;
  logic                     avail;
  logic                     ovf;
  logic                     last;
  logic                     skewed;
  logic [EW-1:0]            cur;
  logic [SCR_W+63:0]        dsc;
  logic [63:0]              pay;
  logic [SW-1:0]            sh_err;
  logic [BER_CNT_W:0]       ber_sum;
  logic [AW:0]              fill;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Per-lane marker bytes; replace with the real code table for silicon
  function automatic logic [23:0] am_pattern(input logic [LW-1:0] num);
    logic [7:0] b;
    b = 8'(num);
    return {b ^ 8'hA5, ~b, b};
  endfunction : am_pattern

  // Returns {hit, lane number}; parity and inverted parity bytes ignored
  function automatic logic [LW:0] am_match(input logic [BLK_W-1:0] b);
    logic [23:0] p;
    logic [23:0] lo;
    logic [23:0] hi;
    logic [LW:0] r;
    lo = b[AM_LO_POS +: 24];
    hi = b[AM_HI_POS +: 24];
    r  = '0;
    for (int k = 0; k < LANES; k++) begin
      p = am_pattern(LW'(k));
      if (b[1:0] == SH_CTRL &&
          ((lo == p && hi == ~p) || (lo == ~p && hi == p))) begin
        r = {1'b1, LW'(k)};
      end
    end
    return r;
  endfunction : am_match

  // Bit-interleaved parity; sync bits fold into parity bits 2 and 3
  function automatic logic [7:0] bip_calc(input logic [BLK_W-1:0] b);
    logic [7:0] r;
    r = '0;
    for (int j = 0; j < BLK_W; j++) begin
      if (j < 2) begin
        r[j + 2] = r[j + 2] ^ b[j];
      end else begin
        r[(j - 2) % 8] = r[(j - 2) % 8] ^ b[j];
      end
    end
    return r;
  endfunction : bip_calc

  function automatic logic [LW-1:0] phys_of(
    input logic [LANES-1:0][LW-1:0] map,
    input logic [LW-1:0]            num
  );
    logic [LW-1:0] r;
    r = '0;
    for (int k = 0; k < LANES; k++) begin
      if (map[k] == num) begin
        r = LW'(k);
      end
    end
    return r;
  endfunction : phys_of

  function automatic logic distinct(input logic [LANES-1:0][LW-1:0] map);
    logic r;
    r = 1'b1;
    for (int a = 0; a < LANES; a++) begin
      for (int c = a + 1; c < LANES; c++) begin
        if (map[a] == map[c]) begin
          r = 1'b0;
        end
      end
    end
    return r;
  endfunction : distinct

  // Returns {next state, data}
  function automatic logic [SCR_W+63:0] descramble(
    input logic [SCR_W-1:0] st,
    input logic [63:0]      din
  );
    logic [SCR_W-1:0] s;
    logic [63:0]      d;
    s = st;
    for (int i = 0; i < 64; i++) begin
      d[i] = din[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s    = {s[SCR_W-2:0], din[i]};
    end
    return {s, d};
  endfunction : descramble

  ////////////////////////////////////////////////////////////////////////////
  // Deskew stores, one per lane

  for (genvar l = 0; l < LANES; l++) begin : g_lane_mem
    pda_skew_mem #(
      .W     (EW),
      .DEPTH (DEPTH)
    ) u_mem (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .wr_en_i   (wr_en[l]),
      .wr_addr_i (s_r.wr_ptr[l][AW-1:0]),
      .wr_data_i (wr_data[l]),
      .rd_en_i   (rd_en),
      .rd_addr_i (s_r.rd_ptr[AW-1:0]),
      .rd_data_o (rd_data[l])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt   = s_r;
    wr_en   = '0;
    wr_data = '0;
    rd_en   = 1'b0;
    hit     = '0;
    at_pos  = 1'b0;
    mark    = 1'b0;
    avail   = 1'b1;
    ovf     = 1'b0;
    skewed  = 1'b0;
    cur     = '0;
    dsc     = '0;
    pay     = '0;
    sh_err  = '0;
    fill    = '0;
    last    = (s_r.idx == LW'(LANES - 1));

    for (int l = 0; l < LANES; l++) begin
      hit    = am_match(lane_blk_i[l].blk);
      at_pos = (s_r.cnt[l] == CW'(AM_PERIOD - 1));
      mark   = 1'b0;
      if (lane_blk_i[l].valid) begin
        s_nxt.cnt[l] = at_pos ? '0 : s_r.cnt[l] + 1'b1;
        s_nxt.bip[l] = s_r.bip[l] ^ bip_calc(lane_blk_i[l].blk);
        if (lane_blk_i[l].blk[0] == lane_blk_i[l].blk[1]) begin
          sh_err = sh_err + 1'b1;
        end
        unique case (s_r.aml[l])
          AML_FIND: begin
            // Every arriving block is a candidate, so all slots are tried
            if (block_lock_i[l] && hit[LW]) begin
              s_nxt.aml[l]      = AML_CONFIRM;
              s_nxt.init_num[l] = hit[LW-1:0];
              s_nxt.cnt[l]      = '0;
              s_nxt.bip[l]      = bip_calc(lane_blk_i[l].blk);
            end
          end
          AML_CONFIRM: begin
            if (at_pos) begin
              s_nxt.aml[l] = (hit[LW] && hit[LW-1:0] == s_r.init_num[l])
                           ? AML_LOCKED : AML_FIND;
              s_nxt.bip[l] = bip_calc(lane_blk_i[l].blk);
            end
          end
          AML_LOCKED: begin
            if (at_pos) begin
              mark         = 1'b1;
              s_nxt.bip[l] = bip_calc(lane_blk_i[l].blk);
              if (lane_blk_i[l].blk[AM_PARITY_POS +: 8] != s_r.bip[l] &&
                  ~&s_r.par_cnt[l]) begin
                s_nxt.par_cnt[l] = s_r.par_cnt[l] + 1'b1;
              end
              if (hit[LW] && hit[LW-1:0] == s_r.init_num[l]) begin
                s_nxt.err_cnt[l] = '0;
              end else if (s_r.err_cnt[l] == EC'(AM_ERR_LIMIT - 1)) begin
                s_nxt.aml[l]     = AML_FIND;
                s_nxt.err_cnt[l] = '0;
              end else begin
                s_nxt.err_cnt[l] = s_r.err_cnt[l] + 1'b1;
              end
            end
          end
        endcase
        // Blocks ahead of a lane's first marker are dropped
        if (s_r.dsk != DSK_IDLE && (s_r.started[l] || mark)) begin
          wr_en[l]          = 1'b1;
          wr_data[l]        = {mark, lane_blk_i[l].blk};
          s_nxt.wr_ptr[l]   = s_r.wr_ptr[l] + 1'b1;
          s_nxt.started[l]  = 1'b1;
        end
      end
      if (!block_lock_i[l]) begin
        s_nxt.aml[l]     = AML_FIND;
        s_nxt.err_cnt[l] = '0;
      end
      s_nxt.locked[l] = (s_nxt.aml[l] == AML_LOCKED);
      fill = s_r.wr_ptr[l] - s_r.rd_ptr;
      if (fill == '0) begin
        avail = 1'b0;
      end
      if (fill >= (AW + 1)'(FL)) begin
        ovf = 1'b1;
      end
    end
    s_nxt.all_locked = &s_nxt.locked;

    // Deskew control
    unique case (s_r.dsk)
      DSK_IDLE: begin
        if (s_r.all_locked && distinct(s_r.init_num)) begin
          s_nxt.dsk     = DSK_WAIT;
          s_nxt.started = '0;
          s_nxt.wr_ptr  = '0;
        end
      end
      DSK_WAIT: begin
        if (&s_r.started) begin
          s_nxt.dsk = DSK_RUN;
        end
      end
      DSK_RUN: begin
        if (s_r.rd_pend) begin
          s_nxt.row      = rd_data;
          s_nxt.row_full = 1'b1;
          s_nxt.idx      = '0;
          s_nxt.rd_pend  = 1'b0;
          for (int l = 1; l < LANES; l++) begin
            if (rd_data[l][EW-1] != rd_data[0][EW-1]) begin
              skewed = 1'b1;
            end
          end
        end
        if (avail && !s_r.rd_pend && (!s_r.row_full || last)) begin
          rd_en          = 1'b1;
          s_nxt.rd_pend  = 1'b1;
          s_nxt.rd_ptr   = s_r.rd_ptr + 1'b1;
        end
      end
    endcase

    // Output stream
    s_nxt.mii = '0;
    if (!s_r.align) begin
      s_nxt.mii = '{valid: 1'b1, rxc: LF_RXC, rxd: LF_RXD};
    end else if (s_r.row_full) begin
      cur = s_r.row[phys_of(s_r.init_num, s_r.idx)];
      s_nxt.idx = s_r.idx + 1'b1;
      if (last) begin
        s_nxt.row_full = 1'b0;
      end
      s_nxt.mii.valid = 1'b1;
      if (cur[EW-1]) begin
        s_nxt.mii.rxc = MII_ALL_CTRL;
        s_nxt.mii.rxd = {8{MII_IDLE}};
      end else begin
        dsc       = descramble(s_r.scr, cur[BLK_W-1:2]);
        s_nxt.scr = dsc[SCR_W+63:64];
        pay       = dsc[63:0];
        if (cur[1:0] == SH_DATA) begin
          s_nxt.mii.rxc = '0;
          s_nxt.mii.rxd = pay;
        end else if (cur[1:0] == SH_CTRL && pay[7:0] == CTRL_IDLE_TYPE &&
                     pay[63:8] == '0) begin
          s_nxt.mii.rxc = MII_ALL_CTRL;
          s_nxt.mii.rxd = {8{MII_IDLE}};
        end else begin
          s_nxt.mii.rxc = MII_ALL_CTRL;
          s_nxt.mii.rxd = {8{MII_ERROR}};
        end
        if (test_mode_i && ~&s_r.test_cnt &&
            !(cur[1:0] == SH_CTRL && pay == 64'(CTRL_IDLE_TYPE))) begin
          s_nxt.test_cnt = s_r.test_cnt + 1'b1;
        end
      end
    end

    // Any loss of lock, overflow or marker misalignment restarts deskew
    if (!s_r.all_locked || ovf || skewed) begin
      s_nxt.dsk      = DSK_IDLE;
      s_nxt.rd_ptr   = '0;
      s_nxt.rd_pend  = 1'b0;
      s_nxt.row_full = 1'b0;
      s_nxt.started  = '0;
    end
    s_nxt.dsk_en = (s_nxt.dsk != DSK_IDLE);
    s_nxt.align  = s_nxt.all_locked && distinct(s_nxt.init_num) &&
                   s_nxt.dsk == DSK_RUN;
    s_nxt.link_good = s_r.align && !s_r.high_error_rate_flag;

    // Error-rate monitor, idle during test mode
    ber_sum = {1'b0, s_r.ber_cnt} + (BER_CNT_W + 1)'(sh_err);
    if (test_mode_i) begin
      s_nxt.ber_cnt = '0;
      s_nxt.ber_win = '0;
      s_nxt.high_error_rate_flag  = 1'b0;
    end else if (s_r.ber_win == BWW'(BER_WINDOW - 1)) begin
      s_nxt.ber_win = '0;
      s_nxt.ber_cnt = '0;
      s_nxt.high_error_rate_flag  = (s_r.ber_cnt >= HIGH_ERROR_RATE_FLAG_THRESH);
    end else begin
      s_nxt.ber_win = s_r.ber_win + 1'b1;
      s_nxt.ber_cnt = ber_sum[BER_CNT_W] ? '1 : ber_sum[BER_CNT_W-1:0];
      if (s_nxt.ber_cnt >= HIGH_ERROR_RATE_FLAG_THRESH) begin
        s_nxt.high_error_rate_flag = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mii_o                     = s_r.mii;
  assign lane_marker_locked_o      = s_r.locked;
  assign all_lanes_marker_locked_o = s_r.all_locked;
  assign lane_mapping_o            = s_r.init_num;
  assign deskew_enable_o           = s_r.dsk_en;
  assign align_status_o            = s_r.align;
  assign high_error_rate_flag_o    = s_r.high_error_rate_flag;
  assign link_good_flag_o          = s_r.link_good;
  assign parity_err_cnt_o          = s_r.par_cnt;
  assign test_err_cnt_o            = s_r.test_cnt;

endmodule : pda_lane_align

// >>> bench/pda_lane_align_chk.sv
/*
  Port-level assertions for the lane alignment block.
  Assumes one clock domain and the async active-low reset.
*/
`timescale 1ns/1ps
module pda_lane_align_chk
  import pda_pkg::*;
#(
  parameter int LANES = LANES_40G
) (
  input wire logic                               clock_i,
  input wire logic                               rstn_i,
  input wire logic [LANES-1:0]                   block_lock_i,
  input wire logic                               test_mode_i,
  input wire pda_mii_s                           mii_o,
  input wire logic [LANES-1:0]                   lane_marker_locked_o,
  input wire logic                               all_lanes_marker_locked_o,
  input wire logic [LANES-1:0][LANE_NUM_W-1:0]   lane_mapping_o,
  input wire logic                               deskew_enable_o,
  input wire logic                               align_status_o,
  input wire logic                               high_error_rate_flag_o,
  input wire logic                               link_good_flag_o,
  input wire logic [LANES-1:0][ERR_CNT_W-1:0]    parity_err_cnt_o,
  input wire logic [ERR_CNT_W-1:0]               test_err_cnt_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_link_good: assert property (
    link_good_flag_o == $past(align_status_o && !high_error_rate_flag_o))
    else $error("link good does not follow alignment");
  a_all_locked: assert property (
    all_lanes_marker_locked_o == (&lane_marker_locked_o))
    else $error("all-locked flag differs from lane locks");
  a_align_lock: assert property (
    !all_lanes_marker_locked_o |=> !align_status_o)
    else $error("alignment kept without all lanes locked");
  a_align_dskew: assert property (
    align_status_o |-> $past(deskew_enable_o))
    else $error("alignment without deskew enabled");
  a_fault_fill: assert property (
    $past(rstn_i) && !$past(align_status_o)
      |-> mii_o == {1'b1, LF_RXC, LF_RXD})
    else $error("no local fault while unaligned");
  a_ber_off: assert property (
    $past(test_mode_i) |-> !high_error_rate_flag_o)
    else $error("error-rate flag raised in test mode");
  a_test_step: assert property (
    $changed(test_err_cnt_o) |-> $past(test_mode_i && align_status_o)
      && test_err_cnt_o == $past(test_err_cnt_o) + 16'h0001)
    else $error("test error count moved wrongly");

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    a_lock_drop: assert property (
      !block_lock_i[l] |=> !lane_marker_locked_o[l])
      else $error("lane lock kept without block lock");
    a_map_hold: assert property (
      lane_marker_locked_o[l] && $past(lane_marker_locked_o[l])
        |-> $stable(lane_mapping_o[l]))
      else $error("lane mapping moved while locked");
    a_par_step: assert property (
      $changed(parity_err_cnt_o[l]) |-> $past(lane_marker_locked_o[l])
        && parity_err_cnt_o[l] == $past(parity_err_cnt_o[l]) + 16'h0001)
      else $error("parity count moved wrongly");
  end
endmodule : pda_lane_align_chk

bind pda_lane_align pda_lane_align_chk #(.LANES(LANES)) u_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .block_lock_i(block_lock_i),
  .test_mode_i(test_mode_i), .mii_o(mii_o),
  .lane_marker_locked_o(lane_marker_locked_o),
  .all_lanes_marker_locked_o(all_lanes_marker_locked_o),
  .lane_mapping_o(lane_mapping_o), .deskew_enable_o(deskew_enable_o),
  .align_status_o(align_status_o),
  .high_error_rate_flag_o(high_error_rate_flag_o),
  .link_good_flag_o(link_good_flag_o),
  .parity_err_cnt_o(parity_err_cnt_o), .test_err_cnt_o(test_err_cnt_o)
);

// >>> bench/pda_lane_model.sv
/*
  Far-side source of four permuted, skewed lanes with markers and parity.
  Assumes one block row every 8 clocks; lane l carries PERM[2l+:2].
*/
`timescale 1ns/1ps
module pda_lane_model
  import pda_pkg::*;
#(
  parameter int         AM_PERIOD = 16,
  parameter logic [7:0] PERM      = 8'h00,
  parameter logic [7:0] SKEW      = 8'h00
) (
  input  wire logic           clock_i,
  input  wire logic           rstn_i,
  input  wire logic           idle_i,
  input  wire logic           burst_i,
  input  wire logic           par_err_i,
  input  wire logic           sh_err_i,
  output pda_lane_blk_s [3:0] lane_blk_o
);
  logic [BLK_W-1:0] mem [64][4];
  logic [SCR_W-1:0] scr;
  logic [7:0]       acc [4];
  logic [2:0]       cyc;
  logic             par_pend;
  logic             sh_pend;
  int               r;

  function automatic logic [7:0] fold(input logic [BLK_W-1:0] b);
    fold = 8'h00;
    for (int j = 0; j < BLK_W; j++)
      fold[(j < 2) ? j + 2 : (j - 2) % 8] ^= b[j];
  endfunction : fold

  always @(posedge clock_i or negedge rstn_i) begin : gen
    logic [BLK_W-1:0] b;
    logic [63:0]      pay;
    logic [23:0]      p;
    logic [7:0]       pb;
    logic             o;
    if (!rstn_i) begin
      r = 0;
      scr = '0;
      acc = '{default: 8'h00};
      cyc = 3'h0;
      par_pend = 1'b0;
      sh_pend = 1'b0;
      lane_blk_o <= '0;
    end else begin
      par_pend = par_pend | par_err_i;
      sh_pend = sh_pend | sh_err_i;
      cyc = cyc + 3'h1;
      if (cyc == 3'h0) begin
        for (int n = 0; n < 4; n++) begin
          if (r % AM_PERIOD == 0) begin
            p = {8'(n) ^ 8'hA5, ~8'(n), 8'(n)};
            pb = acc[n] ^ {7'h00, par_pend && n == 0};
            b = {~pb, ~p, pb, p, 2'b01};
            acc[n] = 8'h00;
            if (n == 0)
              par_pend = 1'b0;
          end else begin
            pay = idle_i ? {56'h0, CTRL_IDLE_TYPE} : {48'h0, 8'(r), 8'(n)};
            for (int i = 0; i < 64; i++) begin
              o = pay[i] ^ scr[SCR_TAP_A] ^ scr[SCR_TAP_B];
              scr = {scr[SCR_W-2:0], o};
              b[i+2] = o;
            end
            b[1:0] = idle_i ? 2'b01 : 2'b10;
            if (sh_pend && n == 0)
              b[1:0] = 2'b10;
            if (n == 0)
              sh_pend = 1'b0;
            if (burst_i)
              b[1:0] = 2'b00;
          end
          acc[n] = acc[n] ^ fold(b);
          mem[r % 64][n] = b;
        end
        for (int l = 0; l < 4; l++) begin
          lane_blk_o[l].valid <= (r >= SKEW[2*l+:2]);
          lane_blk_o[l].blk <= mem[(r + 64 - SKEW[2*l+:2]) % 64][PERM[2*l+:2]];
        end
        r++;
      end else begin
        // Idle lines toggle so stale data never looks valid
        for (int l = 0; l < 4; l++)
          lane_blk_o[l] <= {1'b0, ~lane_blk_o[l].blk};
      end
    end
  end
endmodule : pda_lane_model

// >>> bench/tb_pda_lane_align.sv
/*
  Self-checking bench for the lane alignment block.
  Assumes the lane source model and a 20 MHz clock.
*/
`timescale 1ns/1ps
module tb_pda_lane_align;
  import pda_pkg::*;
  localparam logic [7:0]  PERM = {2'd1, 2'd3, 2'd0, 2'd2};
  localparam logic [7:0]  SKEW = {2'd2, 2'd0, 2'd3, 2'd1};
  localparam logic [72:0] LF   = {1'b1, LF_RXC, LF_RXD};

  logic                      clock_i;
  logic                      rstn_i;
  pda_lane_blk_s [3:0]       lane_blk;
  logic [3:0]                block_lock;
  logic                      test_mode;
  logic                      idle;
  logic                      burst;
  logic                      par_err;
  logic                      sh_err;
  logic                      mon;
  logic                      pv;
  pda_mii_s                  mii;
  logic [3:0]                locked;
  logic                      all_locked;
  logic [3:0][LANE_NUM_W-1:0] mapping;
  logic                      dsk_en;
  logic                      align;
  logic                      hiber;
  logic                      link_good;
  logic [3:0][ERR_CNT_W-1:0] par_cnt;
  logic [ERR_CNT_W-1:0]      test_cnt;
  logic [7:0]                row_b;
  int                        err_total = 0;
  int                        checks = 0;
  int                        k = 0;
  int                        ncyc = 0;

  pda_lane_model #(.AM_PERIOD(16), .PERM(PERM), .SKEW(SKEW))
  u_pda_lane_model (
    .clock_i(clock_i), .rstn_i(rstn_i), .idle_i(idle), .burst_i(burst),
    .par_err_i(par_err), .sh_err_i(sh_err), .lane_blk_o(lane_blk));

  pda_lane_align #(.LANES(4), .AM_PERIOD(16), .BER_WINDOW(800))
  u_pda_lane_align (
    .clock_i(clock_i), .rstn_i(rstn_i), .lane_blk_i(lane_blk),
    .block_lock_i(block_lock), .test_mode_i(test_mode), .mii_o(mii),
    .lane_marker_locked_o(locked), .all_lanes_marker_locked_o(all_locked),
    .lane_mapping_o(mapping), .deskew_enable_o(dsk_en),
    .align_status_o(align), .high_error_rate_flag_o(hiber),
    .link_good_flag_o(link_good), .parity_err_cnt_o(par_cnt),
    .test_err_cnt_o(test_cnt));

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic wait_align();
    int n;
    n = 0;
    while (align !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    #1;
    check(align, 1'b1);
  endtask : wait_align

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Rows are found by the gap before them, so k survives mon toggling
  always @(posedge clock_i) begin
    ncyc++;
    if (ncyc == 10000) begin
      err_total++;
      wrap_up();
    end
    if (mii.valid) begin
      if (!pv)
        k = 0;
      if (mon && mii.rxc === 8'h00) begin
        check(mii.rxd[7:0], k);
        if (k == 0)
          row_b = mii.rxd[15:8];
        else
          check(mii.rxd[15:8], row_b);
      end else if (mon)
        check({mii.rxc, mii.rxd}, {MII_ALL_CTRL, {8{MII_IDLE}}});
      k++;
    end else if (mon && pv)
      check(k, 4);
    pv = mii.valid;
  end

  initial begin
    rstn_i = 1'b0;
    block_lock = 4'h0;
    test_mode = 1'b0;
    idle = 1'b0;
    burst = 1'b0;
    par_err = 1'b0;
    sh_err = 1'b0;
    mon = 1'b0;
    cyc(4);
    rstn_i <= 1'b1;
    block_lock <= 4'hF;
    cyc(1);
    #1;
    check({align, locked, dsk_en, par_cnt, test_cnt}, '0);
    check(mii, LF);
    wait_align();
    check({locked, all_locked, dsk_en, par_cnt}, {6'h3F, 64'h0});
    for (int l = 0; l < 4; l++)
      check(mapping[l], PERM[2*l+:2]);
    cyc(16);
    #1;
    check(link_good, 1'b1);
    mon = 1'b1;
    cyc(320);
    par_err <= 1'b1;
    cyc(1);
    par_err <= 1'b0;
    cyc(300);
    #1;
    check({par_cnt, locked, align}, {32'h0, 16'h1, 16'h0, 5'h1F});
    mon = 1'b0;
    idle <= 1'b1;
    cyc(80);
    test_mode <= 1'b1;
    cyc(200);
    #1;
    check({test_cnt, align}, {16'h0, 1'b1});
    sh_err <= 1'b1;
    cyc(1);
    sh_err <= 1'b0;
    cyc(120);
    #1;
    check(test_cnt, 16'h1);
    burst <= 1'b1;
    cyc(480);
    #1;
    check(hiber, 1'b0);
    burst <= 1'b0;
    test_mode <= 1'b0;
    cyc(80);
    burst <= 1'b1;
    cyc(480);
    #1;
    check({hiber, link_good, align}, 3'b101);
    burst <= 1'b0;
    cyc(1700);
    #1;
    check({hiber, link_good}, 2'b01);
    block_lock <= 4'hB;
    cyc(6);
    #1;
    check({locked, all_locked, align}, {4'hB, 2'b00});
    check(mii, LF);
    block_lock <= 4'hF;
    idle <= 1'b0;
    wait_align();
    cyc(16);
    mon = 1'b1;
    cyc(40);
    wrap_up();
  end
endmodule : tb_pda_lane_align
